// ===== cdb_pkg.sv
// Package: register map, field layout and carrier types of the channel register bank
package cdb_pkg;

  localparam int unsigned CDB_NUM_CH     = 4;
  localparam int unsigned CDB_CH_STRIDE  = 12;
  localparam int unsigned CDB_BRN_BASE   = 8'h09;
  localparam int unsigned CDB_TGT_BASE   = 8'h0a;
  localparam int unsigned CDB_DOX_BASE   = 8'h0b;
  localparam int unsigned CDB_ACT_BASE   = 8'h0c;

  localparam logic [15:0] CDB_RESET_VAL  = 16'h0000;
  localparam logic [15:0] CDB_BRN_WMASK  = 16'h0077;
  localparam logic [15:0] CDB_DOX_WMASK  = 16'h007f;

  // Burnout field positions
  localparam int unsigned CDB_NEG_LVL_LO = 5;
  localparam int unsigned CDB_NEG_DIR    = 4;
  localparam int unsigned CDB_OUT_LVL_LO = 1;
  localparam int unsigned CDB_OUT_DIR    = 0;
  // Digital output config field positions
  localparam int unsigned CDB_BOOST_LO   = 2;
  localparam int unsigned CDB_DRV_SEL    = 1;
  localparam int unsigned CDB_SRC_EN     = 0;

  localparam int unsigned CDB_CLK_NS     = 50;
  localparam int unsigned CDB_BOOST_W    = 22;

  // Boost duration per code in ns, code 0 is bypass
  localparam logic [31:0] CDB_BOOST_NS [32] = '{
    32'd0,        32'd100812,   32'd100812,   32'd100812,   32'd100812,   32'd100812,
    32'd100812,   32'd100812,   32'd130080,   32'd180486,   32'd240648,   32'd320322,
    32'd420321,   32'd560157,   32'd750399,   32'd1000803,  32'd1300800,  32'd1800795,
    32'd2400789,  32'd3200781,  32'd4200771,  32'd5600757,  32'd7500738,  32'd10000713,
    32'd13000683, 32'd18000633, 32'd24000573, 32'd32000493, 32'd42000393, 32'd56000253,
    32'd75000063, 32'd100000626};

  typedef enum logic [1:0] {CDB_K_BRN, CDB_K_TGT, CDB_K_DOX, CDB_K_ACT} cdb_kind_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] ch;
    cdb_kind_t  kind;
  } cdb_dec_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cdb_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } cdb_reg_rsp_t;

  typedef struct packed {
    logic       fet_on;
    logic       leak_comp_active;
    logic       boost_active;
    logic       sourcing_enabled;
    logic [1:0] neg_sense_burnout_level;
    logic       neg_sense_burnout_dir;
    logic [1:0] out_pin_burnout_level;
    logic       out_pin_burnout_dir;
  } cdb_chan_out_t;

endpackage

// ===== cdb_dac_path.sv
// Module: one channel converter code path with deferred load and slewing
`timescale 1ns/10ps
module cdb_dac_path (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_code,
  input  wire logic [15:0] wdata,
  input  wire logic        hold_for_load_cmd,
  input  wire logic        load_converter,
  input  wire logic        slew_enable,
  output logic [15:0]      target_code,
  output logic [15:0]      active_code
);

  typedef struct packed {
    logic [15:0] target;
    logic [15:0] applied;
    logic [15:0] active;
  } cdb_dac_st_t;

  cdb_dac_st_t s_r;
  cdb_dac_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wr_code) begin
      s_nxt.target = wdata;
      if (!hold_for_load_cmd) begin
        s_nxt.applied = wdata;
      end
    end
    if (load_converter && hold_for_load_cmd) begin
      s_nxt.applied = s_nxt.target;
    end
    // Slewing walks one code per clock so the live code shows the position
    if (!slew_enable) begin
      s_nxt.active = s_nxt.applied;
    end else if (s_r.active < s_r.applied) begin
      s_nxt.active = s_r.active + 16'h0001;
    end else if (s_r.active > s_r.applied) begin
      s_nxt.active = s_r.active - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign target_code = s_r.target;
  assign active_code = s_r.active;

  property p_imm_pass;
    @(posedge clk) disable iff (rst)
    (wr_code && !hold_for_load_cmd && !slew_enable) |=> (active_code == $past(wdata));
  endproperty
  a_imm_pass: assert property (p_imm_pass) else $error("Immediate code not applied");

  property p_held;
    @(posedge clk) disable iff (rst)
    (wr_code && hold_for_load_cmd && !load_converter) |=> (s_r.applied == $past(s_r.applied));
  endproperty
  a_held: assert property (p_held) else $error("Held code reached converter");

  sequence s_load;
    hold_for_load_cmd && load_converter && !wr_code;
  endsequence
  property p_load;
    @(posedge clk) disable iff (rst)
    s_load |=> (s_r.applied == $past(s_r.target));
  endproperty
  a_load: assert property (p_load) else $error("Load did not apply target");

  property p_slew_step;
    @(posedge clk) disable iff (rst)
    (slew_enable && s_r.active < s_r.applied) |=> (active_code == $past(active_code) + 16'h0001);
  endproperty
  a_slew_step: assert property (p_slew_step) else $error("Slew step wrong");

  property p_slew_down;
    @(posedge clk) disable iff (rst)
    (slew_enable && s_r.active > s_r.applied) |=> (active_code == $past(active_code) - 16'h0001);
  endproperty
  a_slew_down: assert property (p_slew_down) else $error("Slew down step wrong");

endmodule // cdb_dac_path

// ===== cdb_chan_regs.sv
// Module: four-channel burnout, digital output and converter code register bank
`timescale 1ns/10ps
module cdb_chan_regs #(
  parameter int unsigned BOOST_SHIFT = 0
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire cdb_pkg::cdb_reg_req_t      reg_req,
  output cdb_pkg::cdb_reg_rsp_t           reg_rsp,
  input  wire logic                       hold_for_load_cmd,
  input  wire logic                       load_converter,
  input  wire logic [3:0]                 timeout_alert,
  input  wire logic [3:0]                 sourcing_output_mode,
  input  wire logic [3:0]                 leak_comp_enable,
  input  wire logic [3:0]                 gpio_fet_drive,
  input  wire logic [3:0]                 sw_output_level,
  input  wire logic [3:0]                 slew_enable,
  output cdb_pkg::cdb_chan_out_t [3:0]    chan_out,
  output logic [3:0][15:0]                converter_code
);

  typedef struct packed {
    logic [3:0][15:0]                        brn;
    logic [3:0][15:0]                        dox;
    logic [3:0]                              fet;
    logic [3:0]                              leak;
    logic [3:0][cdb_pkg::CDB_BOOST_W-1:0]    boost_cnt;
    logic [3:0]                              boost;
    cdb_pkg::cdb_reg_rsp_t                   rsp;
  } cdb_st_t;

  cdb_st_t          s_r;
  cdb_st_t          s_nxt;
  cdb_pkg::cdb_dec_t dec;
  logic [3:0]       wr_tgt;
  logic [3:0][15:0] tgt_q;
  logic [3:0][15:0] act_q;

  function automatic cdb_pkg::cdb_dec_t cdb_decode(input logic [7:0] a);
    cdb_decode = '0;
    for (int c = 0; c < cdb_pkg::CDB_NUM_CH; c++) begin
      if (a == 8'(cdb_pkg::CDB_BRN_BASE + c * cdb_pkg::CDB_CH_STRIDE)) begin
        cdb_decode = '{1'b1, 2'(c), cdb_pkg::CDB_K_BRN};
      end
      if (a == 8'(cdb_pkg::CDB_TGT_BASE + c * cdb_pkg::CDB_CH_STRIDE)) begin
        cdb_decode = '{1'b1, 2'(c), cdb_pkg::CDB_K_TGT};
      end
      if (a == 8'(cdb_pkg::CDB_DOX_BASE + c * cdb_pkg::CDB_CH_STRIDE)) begin
        cdb_decode = '{1'b1, 2'(c), cdb_pkg::CDB_K_DOX};
      end
      if (a == 8'(cdb_pkg::CDB_ACT_BASE + c * cdb_pkg::CDB_CH_STRIDE)) begin
        cdb_decode = '{1'b1, 2'(c), cdb_pkg::CDB_K_ACT};
      end
    end
  endfunction

  // Rounded down, so the raised limit never outlasts the coded time
  function automatic logic [cdb_pkg::CDB_BOOST_W-1:0] cdb_boost_cycles(input logic [4:0] code);
    logic [31:0] cyc;
    cyc = (cdb_pkg::CDB_BOOST_NS[code] / cdb_pkg::CDB_CLK_NS) >> BOOST_SHIFT;
    cdb_boost_cycles = cyc[cdb_pkg::CDB_BOOST_W-1:0];
  endfunction

  always_comb begin
    s_nxt = s_r;
    dec = cdb_decode(reg_req.addr);
    wr_tgt = '0;
    s_nxt.rsp.valid = reg_req.rd;
    s_nxt.rsp.data = cdb_pkg::CDB_RESET_VAL;
    if (reg_req.wr && dec.hit) begin
      unique case (dec.kind)
        cdb_pkg::CDB_K_BRN: s_nxt.brn[dec.ch] = reg_req.wdata & cdb_pkg::CDB_BRN_WMASK;
        cdb_pkg::CDB_K_DOX: s_nxt.dox[dec.ch] = reg_req.wdata & cdb_pkg::CDB_DOX_WMASK;
        cdb_pkg::CDB_K_TGT: wr_tgt[dec.ch] = 1'b1;
        cdb_pkg::CDB_K_ACT: ;
      endcase
    end
    for (int c = 0; c < cdb_pkg::CDB_NUM_CH; c++) begin
      // Alert beats a same-cycle write so sourcing cannot be re-armed mid-fault
      if (timeout_alert[c]) begin
        s_nxt.dox[c][cdb_pkg::CDB_SRC_EN] = 1'b0;
      end
      s_nxt.fet[c] = s_nxt.dox[c][cdb_pkg::CDB_DRV_SEL] ? gpio_fet_drive[c]
                                                        : sw_output_level[c];
      s_nxt.leak[c] = leak_comp_enable[c]
                      & ~(s_nxt.dox[c][cdb_pkg::CDB_SRC_EN] & sourcing_output_mode[c]);
      if (s_nxt.fet[c] && !s_r.fet[c]) begin
        s_nxt.boost_cnt[c] = cdb_boost_cycles(
          s_nxt.dox[c][cdb_pkg::CDB_BOOST_LO +: 5]);
      end else if (!s_nxt.fet[c]) begin
        s_nxt.boost_cnt[c] = '0;
      end else if (s_r.boost_cnt[c] != '0) begin
        s_nxt.boost_cnt[c] = s_r.boost_cnt[c] - 1'b1;
      end
      s_nxt.boost[c] = (s_nxt.boost_cnt[c] != '0);
    end
    if (reg_req.rd && dec.hit) begin
      unique case (dec.kind)
        cdb_pkg::CDB_K_BRN: s_nxt.rsp.data = s_r.brn[dec.ch];
        cdb_pkg::CDB_K_DOX: s_nxt.rsp.data = s_r.dox[dec.ch];
        cdb_pkg::CDB_K_TGT: s_nxt.rsp.data = tgt_q[dec.ch];
        cdb_pkg::CDB_K_ACT: s_nxt.rsp.data = act_q[dec.ch];
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Deferred load is shared by all channels, one command updates every held code
  for (genvar g = 0; g < cdb_pkg::CDB_NUM_CH; g++) begin : g_ch
    cdb_dac_path u_path (
      .clk               (clk),
      .rst               (rst),
      .wr_code           (wr_tgt[g]),
      .wdata             (reg_req.wdata),
      .hold_for_load_cmd (hold_for_load_cmd),
      .load_converter    (load_converter),
      .slew_enable       (slew_enable[g]),
      .target_code       (tgt_q[g]),
      .active_code       (act_q[g])
    );
    assign converter_code[g] = act_q[g];
    assign chan_out[g] = '{
      fet_on:                  s_r.fet[g],
      leak_comp_active:        s_r.leak[g],
      boost_active:            s_r.boost[g],
      sourcing_enabled:        s_r.dox[g][cdb_pkg::CDB_SRC_EN],
      neg_sense_burnout_level: s_r.brn[g][cdb_pkg::CDB_NEG_LVL_LO +: 2],
      neg_sense_burnout_dir:   s_r.brn[g][cdb_pkg::CDB_NEG_DIR],
      out_pin_burnout_level:   s_r.brn[g][cdb_pkg::CDB_OUT_LVL_LO +: 2],
      out_pin_burnout_dir:     s_r.brn[g][cdb_pkg::CDB_OUT_DIR]};
  end

  assign reg_rsp = s_r.rsp;

  property p_timeout_clear;
    @(posedge clk) disable iff (rst)
    timeout_alert[0] |=> !chan_out[0].sourcing_enabled;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) else $error("Sourcing not cleared on alert");

  property p_leak_forced;
    @(posedge clk) disable iff (rst)
    (s_nxt.dox[1][cdb_pkg::CDB_SRC_EN] && sourcing_output_mode[1]) |=> !chan_out[1].leak_comp_active;
  endproperty
  a_leak_forced: assert property (p_leak_forced) else $error("Leak compensation not forced off");

  property p_drv_pin;
    @(posedge clk) disable iff (rst)
    s_nxt.dox[0][cdb_pkg::CDB_DRV_SEL] |=> (chan_out[0].fet_on == $past(gpio_fet_drive[0]));
  endproperty
  a_drv_pin: assert property (p_drv_pin) else $error("FET not from pin");

  property p_drv_sw;
    @(posedge clk) disable iff (rst)
    !s_nxt.dox[0][cdb_pkg::CDB_DRV_SEL] |=> (chan_out[0].fet_on == $past(sw_output_level[0]));
  endproperty
  a_drv_sw: assert property (p_drv_sw) else $error("FET not from software level");

  property p_brn_rsvd;
    @(posedge clk) disable iff (rst)
    (reg_req.rd && dec.hit && dec.kind == cdb_pkg::CDB_K_BRN)
      |=> reg_rsp.valid && ((reg_rsp.data & ~cdb_pkg::CDB_BRN_WMASK) == 16'h0000);
  endproperty
  a_brn_rsvd: assert property (p_brn_rsvd) else $error("Reserved burnout bits nonzero");

  property p_boost_start;
    @(posedge clk) disable iff (rst)
    ($rose(chan_out[0].fet_on) && s_r.dox[0][cdb_pkg::CDB_BOOST_LO +: 5] == 5'h00) |-> !chan_out[0].boost_active;
  endproperty
  a_boost_start: assert property (p_boost_start) else $error("Boost active in bypass");

  property p_brn_write;
    @(posedge clk) disable iff (rst)
    (reg_req.wr && reg_req.addr == 8'(cdb_pkg::CDB_BRN_BASE + cdb_pkg::CDB_CH_STRIDE))
      |=> (chan_out[1].neg_sense_burnout_level == $past(reg_req.wdata[6:5]));
  endproperty
  a_brn_write: assert property (p_brn_write) else $error("Channel 1 burnout level not stored");

  property p_alert_beats_write;
    @(posedge clk) disable iff (rst)
    (timeout_alert[1] && reg_req.wr && dec.hit && dec.kind == cdb_pkg::CDB_K_DOX && dec.ch == 2'd1)
      |=> !chan_out[1].sourcing_enabled;
  endproperty
  a_alert_beats_write: assert property (p_alert_beats_write) else $error("Write re-armed sourcing");

  // Turning the FET off must drop the raised limit at once
  property p_boost_cancel;
    @(posedge clk) disable iff (rst)
    !chan_out[0].fet_on |-> !chan_out[0].boost_active;
  endproperty
  a_boost_cancel: assert property (p_boost_cancel) else $error("Boost without FET on");

  sequence s_fet_rise0;
    $rose(chan_out[0].fet_on);
  endsequence
  sequence s_boost_coded0;
    s_r.dox[0][cdb_pkg::CDB_BOOST_LO +: 5] != 5'h00;
  endsequence
  property p_boost_arm;
    @(posedge clk) disable iff (rst)
    s_fet_rise0 ##0 s_boost_coded0 |-> chan_out[0].boost_active;
  endproperty
  a_boost_arm: assert property (p_boost_arm) else $error("Boost not armed on FET turn-on");

endmodule // cdb_chan_regs

// ===== cdb_host_model.sv
// Host model: register traffic on the register port
`timescale 1ns/10ps
module cdb_host_model #(
  parameter int unsigned SETTLE_CYC = 6000
) (
  input  wire logic                  clk,
  output cdb_pkg::cdb_reg_req_t      req,
  input  wire cdb_pkg::cdb_reg_rsp_t rsp
);
  initial req = '0;

  // Released lines show inverted values, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    d = rsp.valid ? rsp.data : 16'hxxxx;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
  endtask

  // Zero the code first, then let the channel settle
  task automatic change_function(input int ch);
    wr(8'(cdb_pkg::CDB_TGT_BASE + 12 * ch), 16'h0000);
    repeat (SETTLE_CYC) @(negedge clk);
  endtask
endmodule // cdb_host_model

// ===== channel_dac_burnout_output_regs_test.sv
// Testbench: self-checking run of the channel register bank
`timescale 1ns/10ps
module channel_dac_burnout_output_regs_test;
  localparam int unsigned SHIFT = 8;
  logic                         clk = 1'b0;
  logic                         rst = 1'b1;
  cdb_pkg::cdb_reg_req_t        req;
  cdb_pkg::cdb_reg_rsp_t        rsp;
  logic                         hold = 1'b0;
  logic                         load = 1'b0;
  logic [3:0]                   alert = '0, mode = '0, leak = '0, gpio = '0, swl = '0, slew = '0;
  cdb_pkg::cdb_chan_out_t [3:0] co;
  logic [3:0][15:0]             cc;
  logic [15:0]                  rv, d, e;
  int                           failures = 0;
  int                           compares = 0;

  always #25 clk = ~clk;

  cdb_host_model #(.SETTLE_CYC(40)) u_host (.clk(clk), .req(req), .rsp(rsp));
  cdb_chan_regs #(.BOOST_SHIFT(SHIFT)) u_dut (.clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp),
    .hold_for_load_cmd(hold), .load_converter(load), .timeout_alert(alert), .sourcing_output_mode(mode),
    .leak_comp_enable(leak), .gpio_fet_drive(gpio), .sw_output_level(swl), .slew_enable(slew),
    .chan_out(co), .converter_code(cc));

  function automatic logic [7:0] ra(input int unsigned base, input int ch);
    return 8'(base + 12 * ch);
  endfunction

  function automatic int unsigned boost_cycles(input int code);
    return (cdb_pkg::CDB_BOOST_NS[code] / cdb_pkg::CDB_CLK_NS) >> SHIFT;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Whole run is about 1230 cycles
  initial begin
    cyc(20000);
    failures++;
    conclude();
  end

  initial begin
    rv = 16'($urandom(32'h5521));
    cyc(20);
    rst = 1'b0;
    for (int ch = 0; ch < 4; ch++) begin
      u_host.rd(ra(cdb_pkg::CDB_BRN_BASE, ch), d); chk("burnout reset", 16'h0000, d);
      u_host.rd(ra(cdb_pkg::CDB_TGT_BASE, ch), d); chk("target reset", 16'h0000, d);
      u_host.rd(ra(cdb_pkg::CDB_ACT_BASE, ch), d); chk("live reset", 16'h0000, d);
    end
    u_host.rd(8'hff, d); chk("unmapped", 16'h0000, d);
    $display("test reset done");
    for (int ch = 0; ch < 4; ch++) begin
      rv = 16'($urandom);
      u_host.wr(ra(cdb_pkg::CDB_BRN_BASE, ch), rv);
      u_host.rd(ra(cdb_pkg::CDB_BRN_BASE, ch), d);
      chk("burnout", rv & 16'h0077, d);
      chk("sense level", {14'h0, rv[6:5]}, {14'h0, co[ch].neg_sense_burnout_level});
      chk("sense dir", {15'h0, rv[4]}, {15'h0, co[ch].neg_sense_burnout_dir});
      chk("out level", {14'h0, rv[2:1]}, {14'h0, co[ch].out_pin_burnout_level});
      chk("out dir", {15'h0, rv[0]}, {15'h0, co[ch].out_pin_burnout_dir});
    end
    $display("test burnout done");
    for (int ch = 0; ch < 4; ch++) begin
      rv = 16'($urandom);
      u_host.wr(ra(cdb_pkg::CDB_TGT_BASE, ch), rv);
      cyc(1);
      chk("code now", rv, cc[ch]);
      u_host.rd(ra(cdb_pkg::CDB_ACT_BASE, ch), d); chk("live code", rv, d);
    end
    e = cc[1];
    hold = 1'b1;
    rv = 16'($urandom);
    u_host.wr(ra(cdb_pkg::CDB_TGT_BASE, 1), rv);
    cyc(3);
    chk("held code", e, cc[1]);
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    cyc(1);
    chk("loaded code", rv, cc[1]);
    u_host.rd(ra(cdb_pkg::CDB_TGT_BASE, 1), d); chk("target kept", rv, d);
    hold = 1'b0;
    // Slewing: start low so ten steps up never wrap, then walk back down
    e = rv & 16'h7fff;
    u_host.wr(ra(cdb_pkg::CDB_TGT_BASE, 2), e);
    slew[2] = 1'b1;
    u_host.wr(ra(cdb_pkg::CDB_TGT_BASE, 2), 16'(e + 10));
    cyc(2);
    chk("slewing", 16'h0001, {15'h0, cc[2] !== e && cc[2] !== 16'(e + 10)});
    cyc(20);
    chk("slew end", 16'(e + 10), cc[2]);
    u_host.wr(ra(cdb_pkg::CDB_TGT_BASE, 2), e);
    cyc(5);
    chk("slewing down", 16'(e + 5), cc[2]);
    cyc(20);
    chk("slew back", e, cc[2]);
    slew[2] = 1'b0;
    $display("test converter done");
    u_host.wr(ra(cdb_pkg::CDB_DOX_BASE, 0), 16'(24 << 2));
    swl[0] = 1'b1;
    cyc(3);
    chk("fet soft", 16'h0001, {15'h0, co[0].fet_on});
    chk("boost on", 16'h0001, {15'h0, co[0].boost_active});
    cyc(boost_cycles(24) - 4);
    chk("boost held", 16'h0001, {15'h0, co[0].boost_active});
    cyc(2);
    chk("boost off", 16'h0000, {15'h0, co[0].boost_active});
    swl[0] = 1'b0;
    u_host.wr(ra(cdb_pkg::CDB_DOX_BASE, 0), 16'h0000);
    swl[0] = 1'b1;
    cyc(3);
    chk("boost bypass", 16'h0000, {15'h0, co[0].boost_active});
    // Pin drive: host has set that pin to its FET role
    u_host.wr(ra(cdb_pkg::CDB_DOX_BASE, 0), 16'h0002);
    cyc(3);
    chk("fet pin low", 16'h0000, {15'h0, co[0].fet_on});
    gpio[0] = 1'b1;
    cyc(3);
    chk("fet pin high", 16'h0001, {15'h0, co[0].fet_on});
    $display("test fet done");
    mode[1] = 1'b1;
    leak[1] = 1'b1;
    u_host.wr(ra(cdb_pkg::CDB_DOX_BASE, 1), 16'h0001);
    cyc(3);
    chk("sourcing on", 16'h0001, {15'h0, co[1].sourcing_enabled});
    chk("leak forced off", 16'h0000, {15'h0, co[1].leak_comp_active});
    alert[1] = 1'b1;
    cyc(1);
    alert[1] = 1'b0;
    cyc(2);
    chk("sourcing cleared", 16'h0000, {15'h0, co[1].sourcing_enabled});
    chk("leak back", 16'h0001, {15'h0, co[1].leak_comp_active});
    u_host.rd(ra(cdb_pkg::CDB_DOX_BASE, 1), d); chk("enable bit", 16'h0000, d);
    alert[1] = 1'b1;
    u_host.wr(ra(cdb_pkg::CDB_DOX_BASE, 1), 16'h0001);
    alert[1] = 1'b0;
    cyc(1);
    chk("alert beats write", 16'h0000, {15'h0, co[1].sourcing_enabled});
    $display("test sourcing done");
    u_host.change_function(1);
    u_host.rd(ra(cdb_pkg::CDB_TGT_BASE, 1), d); chk("zeroed code", 16'h0000, d);
    chk("zeroed live", 16'h0000, cc[1]);
    $display("test function change done");
    conclude();
  end
endmodule // channel_dac_burnout_output_regs_test
